/* rtl/perf_state_pkg.sv */
// Contract
// R01: Transitions run only while enable bit 16 set
// R02: Identification query ECX bit 07 reports support
// R03: Writing 16-bit target starts a transition
// R04: Target written mid-transition taken after current one
// R05: Target control reads return last written target
// R06: Status shows current point, updates by itself
// R07: Code mapping implementation specific, invalid codes ignored
// R08: Direct switch, no sleep, no bus hold
// R09: Leaf 06H ECX bit 0 reports feedback counters
// R10: Fixed-rate counter at 0xE7 counts boot rate
// R11: Actual counter at 0xE8 counts delivered performance
// R12: Per-processor counters advance only when fully active
// R13: Either wrap clears both, counting continues
// R14: Full 64-bit counters, independent writes
// R15: Software saves or zeroes counters per window
// R16: Software reads both counters back to back
// R17: Software detects wrap by smaller new reading
// R18: Counters hold zero after reset
package perf_state_pkg;

	// Register indices at the model register port
	localparam logic [31:0] FIXED_RATE_CNT_IDX = 32'h0000_00e7;
	localparam logic [31:0] ACTUAL_PERF_CNT_IDX = 32'h0000_00e8;
	localparam logic [31:0] PERF_STATUS_IDX = 32'h0000_0198;
	localparam logic [31:0] PERF_TARGET_IDX = 32'h0000_0199;
	localparam logic [31:0] MISC_ENABLE_IDX = 32'h0000_0100;

	// Field positions
	localparam int MISC_XFER_EN_BIT = 16;
	localparam int CAP_LEAF01_XFER_BIT = 7;
	localparam int CAP_LEAF06_FB_BIT = 0;
	localparam int CODE_RATIO_LSB = 8;

	// Reset values
	localparam logic [15:0] PERF_CODE_RST = 16'h0000;
	localparam logic [63:0] FB_CNT_RST = 64'h0000_0000_0000_0000;
	localparam logic [7:0] BASE_RATIO_RST = 8'h01;

	// Valid operating-point window, implementation defined
	localparam logic [7:0] RATIO_MIN = 8'h06;
	localparam logic [7:0] RATIO_MAX = 8'h20;
	localparam logic [7:0] VID_MAX = 8'h3f;

	// Timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int SWITCH_TIME_NS = 500;
	localparam int SWITCH_CYCLES =
		(SWITCH_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int REF_TICK_NS = 100;
	localparam int REF_TICK_CYCLES = REF_TICK_NS / CLK_PERIOD_NS;

	typedef enum logic [1:0] {
		XFER_IDLE = 2'b01,
		XFER_SWITCH = 2'b10
	} xfer_state_e;

	typedef struct packed {
		logic rd;
		logic wr;
		logic [31:0] idx;
		logic [63:0] wdata;
	} msr_req_s;

	typedef struct packed {
		logic valid;
		logic fault;
		logic [63:0] data;
	} msr_rsp_s;

endpackage

/* rtl/ref_tick_div.sv */
`timescale 1ns/10ps
module ref_tick_div (
	// Clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	// Control
	input wire logic i_run,
	output logic o_tick
);

	localparam logic [7:0] LAST =
		8'(perf_state_pkg::REF_TICK_CYCLES - 1);

	logic [7:0] cnt_r;
	logic [7:0] cnt_nxt;
	wire at_last = (cnt_r == LAST);

	assign cnt_nxt = (!i_run || at_last) ? 8'h00 : cnt_r + 8'h01;
	assign o_tick = i_run && at_last;

	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cnt_r <= 8'h00;
		end else begin
			cnt_r <= cnt_nxt;
		end
	end

endmodule

/* rtl/fb_counter.sv */
`timescale 1ns/10ps
module fb_counter (
	// Clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	// Control
	input wire logic i_clear,
	input wire logic i_load,
	input wire logic [63:0] i_load_val,
	input wire logic i_inc_en,
	input wire logic [15:0] i_inc_amt,
	// State
	output logic [63:0] o_count,
	output logic o_carry
);

	logic [63:0] cnt_r;
	logic [63:0] cnt_nxt;
	wire [64:0] sum = {1'b0, cnt_r} + {49'h0, i_inc_amt};

	// Load beats clear so a software write is never lost
	assign cnt_nxt = i_load ? i_load_val :
		i_clear ? perf_state_pkg::FB_CNT_RST : // R13
		i_inc_en ? sum[63:0] : cnt_r;
	assign o_carry = i_inc_en && sum[64];
	assign o_count = cnt_r;

	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cnt_r <= perf_state_pkg::FB_CNT_RST; // R18
		end else begin
			cnt_r <= cnt_nxt;
		end
	end

endmodule

/* rtl/perf_state_ctl.sv */
`timescale 1ns/10ps
module perf_state_ctl (
	// Clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	// Model register port
	input wire perf_state_pkg::msr_req_s i_msr_req,
	output perf_state_pkg::msr_rsp_s o_msr_rsp,
	// Processor condition
	input wire logic i_c0_active,
	input wire logic i_throttle_active,
	input wire logic [7:0] i_base_ratio_strap,
	// Identification query results
	output logic [31:0] o_cap_leaf01_ecx,
	output logic [31:0] o_cap_leaf06_ecx,
	// Operating point to clock and voltage control
	output logic [7:0] o_freq_ratio,
	output logic [7:0] o_volt_id,
	output logic o_switching
);

	localparam logic [15:0] SW_LAST =
		16'(perf_state_pkg::SWITCH_CYCLES - 1);

	function automatic logic code_valid(input logic [15:0] code);
		logic [7:0] ratio;
		ratio = code[15:8];
		code_valid = (ratio >= perf_state_pkg::RATIO_MIN) &&
			(ratio <= perf_state_pkg::RATIO_MAX) &&
			(code[7:0] <= perf_state_pkg::VID_MAX);
	endfunction

	// Register decode
	wire wr = i_msr_req.wr;
	wire rd = i_msr_req.rd;
	wire [31:0] idx = i_msr_req.idx;
	wire sel_fix = (idx == perf_state_pkg::FIXED_RATE_CNT_IDX);
	wire sel_act = (idx == perf_state_pkg::ACTUAL_PERF_CNT_IDX);
	wire sel_sts = (idx == perf_state_pkg::PERF_STATUS_IDX);
	wire sel_tgt = (idx == perf_state_pkg::PERF_TARGET_IDX);
	wire sel_misc = (idx == perf_state_pkg::MISC_ENABLE_IDX);
	wire mapped = sel_fix || sel_act || sel_sts || sel_tgt || sel_misc;
	wire wr_tgt = wr && sel_tgt;
	wire wr_misc = wr && sel_misc;

	logic misc_en_r;
	logic [15:0] target_r;
	logic [15:0] status_r;
	logic [15:0] goal_r;
	logic [15:0] timer_r;
	logic [7:0] base_ratio_r;
	logic boot_done_r;
	perf_state_pkg::xfer_state_e state_r;
	perf_state_pkg::msr_rsp_s rsp_r;

	// Transition sequencer
	wire switching = (state_r == perf_state_pkg::XFER_SWITCH);
	wire pending = (target_r != status_r) && code_valid(target_r); // R07
	wire start = misc_en_r && !switching && pending; // R01
	wire done = switching && (timer_r == 16'h0000);
	perf_state_pkg::xfer_state_e state_nxt;
	logic [15:0] timer_nxt;

	always_comb begin
		state_nxt = state_r;
		timer_nxt = timer_r;
		case (state_r)
			perf_state_pkg::XFER_IDLE: begin
				if (start) begin
					state_nxt = perf_state_pkg::XFER_SWITCH;
					timer_nxt = SW_LAST;
				end
			end
			perf_state_pkg::XFER_SWITCH: begin
				// Disabling abandons the switch, point stays put
				if (!misc_en_r || done) begin
					state_nxt = perf_state_pkg::XFER_IDLE;
				end else begin
					timer_nxt = timer_r - 16'h0001;
				end
			end
			default: begin
				state_nxt = perf_state_pkg::XFER_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_r <= perf_state_pkg::XFER_IDLE;
			timer_r <= 16'h0000;
		end else begin
			state_r <= state_nxt;
			timer_r <= timer_nxt;
		end
	end

	// Goal frozen per switch; newer targets wait for the next one
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			goal_r <= perf_state_pkg::PERF_CODE_RST;
		end else if (start) begin
			goal_r <= target_r; // R04
		end
	end

	// Point changes in one step at the end, no sleep or bus hold
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			status_r <= perf_state_pkg::PERF_CODE_RST;
		end else if (done && misc_en_r) begin
			status_r <= goal_r; // R06 R08
		end
	end

	// Software-written registers
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			misc_en_r <= 1'b0; // R01
			target_r <= perf_state_pkg::PERF_CODE_RST;
		end else begin
			if (wr_misc) begin
				misc_en_r <= i_msr_req.wdata[perf_state_pkg::MISC_XFER_EN_BIT];
			end
			if (wr_tgt) begin
				target_r <= i_msr_req.wdata[15:0]; // R03 R05
			end
		end
	end

	// Boot rate captured once after reset release
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			boot_done_r <= 1'b0;
			base_ratio_r <= perf_state_pkg::BASE_RATIO_RST;
		end else if (!boot_done_r) begin
			boot_done_r <= 1'b1;
			base_ratio_r <= i_base_ratio_strap; // R10
		end
	end

	// Feedback counters
	wire tick;
	wire [63:0] cnt [2];
	wire [1:0] carry;
	wire [1:0] load;
	wire [15:0] amt [2];
	wire wrap_any = |carry;
	// Counting only in the fully active state
	wire count_en = i_c0_active && boot_done_r; // R12
	// Throttled cycles deliver nothing
	wire act_en = count_en && !i_throttle_active; // R11

	assign load[0] = wr && sel_fix; // R14
	assign load[1] = wr && sel_act; // R14
	assign amt[0] = {8'h00, base_ratio_r}; // R10
	assign amt[1] = {8'h00, status_r[15:8]}; // R11

	ref_tick_div u_div (
		.i_ref_clk(i_ref_clk),
		.i_rst_n(i_rst_n),
		.i_run(count_en),
		.o_tick(tick)
	);

	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_cnt
			fb_counter u_cnt (
				.i_ref_clk(i_ref_clk),
				.i_rst_n(i_rst_n),
				.i_clear(wrap_any), // R13
				.i_load(load[g]),
				.i_load_val(i_msr_req.wdata),
				.i_inc_en(tick && (g == 0 ? count_en : act_en)),
				.i_inc_amt(amt[g]),
				.o_count(cnt[g]),
				.o_carry(carry[g])
			);
		end
	endgenerate

	// Read path, one cycle latency
	wire [63:0] misc_word = 64'(misc_en_r) << perf_state_pkg::MISC_XFER_EN_BIT;
	wire [63:0] rd_mux = sel_fix ? cnt[0] :
		sel_act ? cnt[1] :
		sel_sts ? {48'h0, status_r} :
		sel_tgt ? {48'h0, target_r} :
		sel_misc ? misc_word : 64'h0;

	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rsp_r <= '0;
		end else begin
			rsp_r.valid <= rd;
			rsp_r.fault <= (rd || wr) && !mapped;
			rsp_r.data <= rd ? rd_mux : 64'h0;
		end
	end

	assign o_msr_rsp = rsp_r;
	assign o_cap_leaf01_ecx =
		32'h1 << perf_state_pkg::CAP_LEAF01_XFER_BIT; // R02
	assign o_cap_leaf06_ecx =
		32'h1 << perf_state_pkg::CAP_LEAF06_FB_BIT; // R09
	assign o_freq_ratio = status_r[15:8];
	assign o_volt_id = status_r[7:0];
	assign o_switching = switching;

	// Age of a running switch, so timing checks need no long repeats
	logic [15:0] sw_age_r;

	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			sw_age_r <= 16'h0000;
		end else begin
			sw_age_r <= switching ? sw_age_r + 16'h0001 : 16'h0000;
		end
	end

	// Checks
	AST_DISABLED_HOLDS: assert property (@(posedge i_ref_clk) // R01
		disable iff (!i_rst_n) !misc_en_r |=> $stable(status_r))
		else $error("operating point moved while disabled");
	AST_CAP_FLAGS: assert property (@(posedge i_ref_clk) // R02
		disable iff (!i_rst_n) o_cap_leaf01_ecx[7] && o_cap_leaf06_ecx[0])
		else $error("capability flag missing");
	AST_TARGET_WRITE: assert property (@(posedge i_ref_clk) // R03
		disable iff (!i_rst_n)
		wr_tgt |=> target_r == $past(i_msr_req.wdata[15:0]))
		else $error("target not stored");
	AST_LATE_TARGET: assert property (@(posedge i_ref_clk) // R04
		disable iff (!i_rst_n)
		switching && !done && misc_en_r && wr_tgt |=> switching &&
		$stable(goal_r))
		else $error("running switch disturbed by new target");
	AST_TARGET_READ: assert property (@(posedge i_ref_clk) // R05
		disable iff (!i_rst_n)
		rd && sel_tgt && !wr |=> o_msr_rsp.valid &&
		o_msr_rsp.data[15:0] == target_r)
		else $error("target readback wrong");
	AST_SWITCH_TIME: assert property (@(posedge i_ref_clk) // R06
		disable iff (!i_rst_n)
		switching && misc_en_r && sw_age_r == SW_LAST |=>
		status_r == $past(goal_r))
		else $error("switch did not land in time");
	AST_SWITCH_BOUND: assert property (@(posedge i_ref_clk) // R08
		disable iff (!i_rst_n) switching |-> sw_age_r <= SW_LAST)
		else $error("switch ran too long");
	AST_VALID_ONLY: assert property (@(posedge i_ref_clk) // R07
		disable iff (!i_rst_n) switching |-> code_valid(goal_r))
		else $error("invalid code started a switch");
	AST_WRAP_BOTH: assert property (@(posedge i_ref_clk) // R13
		disable iff (!i_rst_n)
		wrap_any && load == 2'b00 |=> cnt[0] == 64'h0 && cnt[1] == 64'h0)
		else $error("wrap did not clear both counters");
	AST_IDLE_HOLD: assert property (@(posedge i_ref_clk) // R12
		disable iff (!i_rst_n)
		!i_c0_active && load == 2'b00 |=> $stable(cnt[0]) && $stable(cnt[1]))
		else $error("counter moved outside active state");
	AST_INDEP_WRITE: assert property (@(posedge i_ref_clk) // R14
		disable iff (!i_rst_n)
		load == 2'b01 && !wrap_any && !tick |=> cnt[0] ==
		$past(i_msr_req.wdata) && $stable(cnt[1]))
		else $error("counter write leaked to its partner");
	AST_RATE_STEP: assert property (@(posedge i_ref_clk) // R10
		disable iff (!i_rst_n)
		tick && count_en && !wrap_any && load == 2'b00 |=>
		cnt[0] == $past(cnt[0]) + 64'(base_ratio_r))
		else $error("fixed-rate step wrong");

endmodule

/* test/tb_perf_state_ctl.sv */
`timescale 1ns/10ps
module tb_perf_state_ctl;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	perf_state_pkg::msr_req_s req = '0;
	perf_state_pkg::msr_rsp_s rsp;
	logic c0 = 1'b0;
	logic thr = 1'b0;
	logic [7:0] strap = 8'h03;
	logic [31:0] cap1;
	logic [31:0] cap6;
	logic [7:0] ratio;
	logic [7:0] vid;
	logic sw;
	logic flt;
	logic [63:0] v;
	logic [63:0] fx;
	logic [63:0] ac;
	int fails = 0;
	int comparisons = 0;

	always #5 clk = ~clk;

	perf_state_ctl i_dut (
		.i_ref_clk(clk),
		.i_rst_n(rst_n),
		.i_msr_req(req),
		.o_msr_rsp(rsp),
		.i_c0_active(c0),
		.i_throttle_active(thr),
		.i_base_ratio_strap(strap),
		.o_cap_leaf01_ecx(cap1),
		.o_cap_leaf06_ecx(cap6),
		.o_freq_ratio(ratio),
		.o_volt_id(vid),
		.o_switching(sw)
	);

	task automatic complete_run;
		$display("Counts: %0d compared, %0d failed", comparisons, fails);
		if (fails == 0 && comparisons > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task automatic check(input string what, input logic [63:0] seen,
		input logic [63:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fails++;
			$display("Error %s: expected %h, seen %h", what, exp, seen);
		end
	endtask

	task automatic timed_out(input string what);
		fails++;
		$display("Error %s: expected completion, seen timeout", what);
		complete_run();
	endtask

	// Answer is registered, so look just after the edge that takes the request
	task automatic reg_rd(input logic [31:0] idx, output logic [63:0] val);
		int i;
		@(posedge clk);
		req.rd <= 1'b1;
		req.idx <= idx;
		@(posedge clk);
		req.rd <= 1'b0;
		#1;
		for (i = 0; i < 4 && rsp.valid !== 1'b1; i++) begin
			@(posedge clk);
			#1;
		end
		if (rsp.valid !== 1'b1) begin
			timed_out("read answer");
		end else begin
			flt = rsp.fault;
			val = rsp.data;
		end
	endtask

	task automatic reg_wr(input logic [31:0] idx, input logic [63:0] val);
		@(posedge clk);
		req.wr <= 1'b1;
		req.idx <= idx;
		req.wdata <= val;
		@(posedge clk);
		req.wr <= 1'b0;
	endtask

	task automatic wait_sw(input logic lvl);
		int i;
		for (i = 0; i < 200 && sw !== lvl; i++) begin
			@(posedge clk);
			#1;
		end
		if (sw !== lvl) timed_out("switch wait");
	endtask

	task automatic run_c0(input int n, input logic t);
		@(posedge clk);
		c0 <= 1'b1;
		thr <= t;
		repeat (n) @(posedge clk);
		c0 <= 1'b0;
		thr <= 1'b0;
		reg_rd(perf_state_pkg::FIXED_RATE_CNT_IDX, fx);
		reg_rd(perf_state_pkg::ACTUAL_PERF_CNT_IDX, ac);
	endtask

	task automatic test_reset;
		reg_rd(perf_state_pkg::FIXED_RATE_CNT_IDX, v);
		check("fixed after reset", v, 64'h0);
		reg_rd(perf_state_pkg::ACTUAL_PERF_CNT_IDX, v);
		check("actual after reset", v, 64'h0);
		reg_rd(perf_state_pkg::MISC_ENABLE_IDX, v);
		check("enable after reset", v, 64'h0);
		check("leaf01 flag", 64'(cap1[7]), 64'h1);
		check("leaf06 flag", 64'(cap6[0]), 64'h1);
		$display("reset test done");
	endtask

	// Target is stored but nothing moves while disabled
	task automatic test_disabled;
		reg_wr(perf_state_pkg::PERF_TARGET_IDX, 64'h1020);
		repeat (60) @(posedge clk);
		check("switching off", 64'(sw), 64'h0);
		reg_rd(perf_state_pkg::PERF_STATUS_IDX, v);
		check("status idle", v, 64'h0);
		reg_rd(perf_state_pkg::PERF_TARGET_IDX, v);
		check("target readback", v, 64'h1020);
		$display("disabled test done");
	endtask

	task automatic test_switch;
		reg_wr(perf_state_pkg::MISC_ENABLE_IDX, 64'h1_0000);
		reg_rd(perf_state_pkg::MISC_ENABLE_IDX, v);
		check("enable readback", v, 64'h1_0000);
		reg_wr(perf_state_pkg::PERF_TARGET_IDX, 64'h1020);
		wait_sw(1'b1);
		reg_wr(perf_state_pkg::PERF_TARGET_IDX, 64'h0810);
		reg_rd(perf_state_pkg::PERF_TARGET_IDX, v);
		check("last target", v, 64'h0810);
		reg_rd(perf_state_pkg::PERF_STATUS_IDX, v);
		check("status mid switch", v, 64'h0);
		wait_sw(1'b0);
		check("first point", {48'h0, ratio, vid}, 64'h1020);
		wait_sw(1'b1);
		wait_sw(1'b0);
		reg_rd(perf_state_pkg::PERF_STATUS_IDX, v);
		check("queued point", v, 64'h0810);
		reg_wr(perf_state_pkg::PERF_STATUS_IDX, 64'h1020);
		reg_rd(perf_state_pkg::PERF_STATUS_IDX, v);
		check("status not writable", v, 64'h0810);
		$display("switch test done");
	endtask

	// Ratio 0x40 is outside the window, so it is never applied
	task automatic test_invalid;
		reg_wr(perf_state_pkg::PERF_TARGET_IDX, 64'h4020);
		repeat (60) @(posedge clk);
		check("invalid not applied", {48'h0, ratio, vid}, 64'h0810);
		reg_rd(perf_state_pkg::PERF_TARGET_IDX, v);
		check("invalid stored", v, 64'h4020);
		reg_rd(32'h0000_0123, v);
		check("unmapped fault", 64'(flt), 64'h1);
		check("unmapped data", v, 64'h0);
		$display("invalid test done");
	endtask

	task automatic test_counters;
		reg_wr(perf_state_pkg::FIXED_RATE_CNT_IDX, 64'h0);
		reg_wr(perf_state_pkg::ACTUAL_PERF_CNT_IDX, 64'h0);
		run_c0(100, 1'b0);
		v = 64'(100 / perf_state_pkg::REF_TICK_CYCLES) * 64'(strap);
		check("fixed counts", fx, v);
		check("rate ratio", fx * 64'h8, ac * 64'h3);
		v = fx;
		repeat (50) @(posedge clk);
		reg_rd(perf_state_pkg::FIXED_RATE_CNT_IDX, fx);
		check("fixed idle", fx, v);
		v = ac;
		run_c0(100, 1'b1);
		check("actual throttled", ac, v);
		reg_wr(perf_state_pkg::FIXED_RATE_CNT_IDX, 64'h55);
		reg_rd(perf_state_pkg::ACTUAL_PERF_CNT_IDX, v);
		check("write independent", v, ac);
		reg_rd(perf_state_pkg::FIXED_RATE_CNT_IDX, v);
		check("fixed written", v, 64'h55);
		v = 64'hffff_ffff_ffff_fffe;
		reg_wr(perf_state_pkg::FIXED_RATE_CNT_IDX, v);
		reg_wr(perf_state_pkg::ACTUAL_PERF_CNT_IDX, 64'h100);
		run_c0(12, 1'b0);
		check("fixed wrapped", 64'(fx < 64'h100), 64'h1);
		check("wrap seen smaller", 64'(fx < v), 64'h1);
		check("actual cleared", 64'(ac < 64'h100), 64'h1);
		$display("counter test done");
	endtask

	initial begin
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		test_reset();
		test_disabled();
		test_switch();
		test_invalid();
		test_counters();
		complete_run();
	end
endmodule
